/* File: logic/sie_pkg.sv */
// package: constants and carrier types of the serial i/o expander
package sie_pkg;
  // register command codes
  localparam logic [7:0] CMD_CFG = 8'h00;
  localparam logic [7:0] CMD_DIR = 8'h01;
  localparam logic [7:0] CMD_DRV = 8'h02;
  localparam logic [7:0] CMD_STAT = 8'h03;
  localparam logic [7:0] CMD_MASK = 8'h04;
  localparam logic [7:0] CMD_DATA = 8'h05;
  localparam logic [7:0] CMD_FAN = 8'h06;
  // device_config_reg field positions
  localparam int CFG_FAN_BIT = 0;
  localparam int CFG_IE_BIT = 1;
  // power-on values
  localparam logic [7:0] RST_CFG = 8'h00;
  localparam logic [7:0] RST_DIR = 8'h00;
  localparam logic [7:0] RST_DRV = 8'h00;
  localparam logic [7:0] RST_STAT = 8'h00;
  localparam logic [7:0] RST_MASK = 8'h00;
  localparam logic [7:0] RST_DATA = 8'hFF;
  localparam logic [7:0] RST_FAN = 8'h00;
  // client address upper bits and alert response address
  localparam logic [3:0] ADDR_BASE = 4'h4;
  localparam logic [6:0] ARA_ADDR = 7'h0C;
  // bus free time, counted on the link clock
  localparam int BUS_FREE_NS = 50000;
  localparam int LNK_PERIOD_NS = 15;
  localparam int IDLE_CYC = BUS_FREE_NS / LNK_PERIOD_NS + 1;
  localparam int IDLE_W = 12;
  // register image
  typedef struct packed {
    logic [7:0] cfg;
    logic [7:0] dir;
    logic [7:0] drv;
    logic [7:0] stat;
    logic [7:0] mask;
    logic [7:0] data;
    logic [7:0] fan;
  } sie_regs_type;
  localparam sie_regs_type RST_REGS = '{RST_CFG, RST_DIR, RST_DRV, RST_STAT,
                                        RST_MASK, RST_DATA, RST_FAN};
  // write request held by the link side
  typedef struct packed {
    logic [7:0] cmd;
    logic [7:0] dat;
  } sie_wr_type;
endpackage : sie_pkg

/* File: logic/sie_sync.sv */
// two flip-flop level synchroniser
`timescale 1ns/1ps
`default_nettype none
module sie_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // level in, level out
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);
  // both stages in one state word
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sie_sync_type;
  sie_sync_type r_ff;
  sie_sync_type nxt_r;

  // first stage feeds only the second
  always_comb
  begin
    nxt_r.s1 = i_d;
    nxt_r.s2 = r_ff.s1;
  end

  // register stages
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      r_ff <= '0;
    else
      r_ff <= nxt_r;
  end

  assign o_q = r_ff.s2;
endmodule : sie_sync
`default_nettype wire

/* File: logic/sie_port.sv */
// expander line drivers and input change detection
`timescale 1ns/1ps
`default_nettype none
module sie_port (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // register image
  input wire sie_pkg::sie_regs_type i_regs,
  // expander line pins
  input wire logic [7:0] i_line,
  output logic [7:0] o_line,
  output logic [7:0] o_line_oe,
  // per-line change pulses
  output logic [7:0] o_evt
);
  // port state
  typedef struct packed {
    logic [7:0] prev;
    logic [7:0] lvl;
    logic [7:0] oe;
    logic [7:0] evt;
    logic [1:0] warm; // synchroniser fill count after reset
  } sie_port_type;
  sie_port_type p_ff;
  sie_port_type nxt_p;
  logic [7:0] line_s; // synchronised pins

  // pins cross in before use
  sie_sync #(.W(8)) u_lsync (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_d(i_line),
    .o_q(line_s)
  );

  // drive and change logic
  always_comb
  begin
    logic fan_on;
    logic [7:0] watch;
    logic [3:0] fan_lvl;
    fan_on = i_regs.cfg[sie_pkg::CFG_FAN_BIT];
    // only input lines outside fan mode are watched
    watch = ~i_regs.dir;
    // fan pins: shutdown pulled low at level zero, speed bits active low
    fan_lvl = {~i_regs.fan[2:0], |i_regs.fan[2:0]};
    nxt_p = p_ff;
    nxt_p.prev = line_s;
    // no events until both stages and prev hold real pin levels
    if (p_ff.warm != 2'h3)
      nxt_p.warm = p_ff.warm + 2'h1;
    if (fan_on)
      watch[7:4] = 4'h0;
    if (p_ff.warm != 2'h3)
      watch = 8'h00;
    nxt_p.evt = (line_s ^ p_ff.prev) & watch;
    for (int i = 0; i < 8; i++)
    begin
      if (i_regs.dir[i])
      begin
        // output line follows data at once
        nxt_p.lvl[i] = i_regs.drv[i] & i_regs.data[i];
        nxt_p.oe[i] = i_regs.drv[i] | ~i_regs.data[i];
      end
      else
      begin
        // input line released
        nxt_p.lvl[i] = 1'b0;
        nxt_p.oe[i] = 1'b0;
      end
    end
    // fan mode takes the upper lines, all open-drain
    if (fan_on)
    begin
      nxt_p.lvl[7:4] = 4'h0;
      nxt_p.oe[7:4] = ~fan_lvl;
    end
  end

  // state register, lines released at reset
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      p_ff <= '0;
    else
      p_ff <= nxt_p;
  end

  assign o_line = p_ff.lvl;
  assign o_line_oe = p_ff.oe;
  assign o_evt = p_ff.evt;

  AST_OUT_DRIVE : assert property (@(posedge i_clk) disable iff (!i_nrst)
    (i_regs.dir[0] && i_regs.drv[0]) |=> (p_ff.oe[0] && p_ff.lvl[0] == $past(i_regs.data[0])))
    else $error("output line not driven from data");
endmodule : sie_port
`default_nettype wire

/* File: logic/sie_core.sv */
// serial i/o expander core: bus engine, registers, alert
`timescale 1ns/1ps
`default_nettype none
module sie_core (
  // clocks and reset
  input wire logic i_clk,
  input wire logic i_lnk_clk,
  input wire logic i_nrst,
  // serial bus pins
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda,
  output logic o_sda_oe,
  // address straps
  input wire logic [2:0] i_addr_sel,
  // expander lines
  input wire logic [7:0] i_line,
  output logic [7:0] o_line,
  output logic [7:0] o_line_oe,
  // notification and bus state
  output logic o_alert_n,
  output logic o_bus_busy
);
  // link engine states
  typedef enum logic [4:0] {
    LS_IDLE = 5'h01,
    LS_RECV = 5'h02,
    LS_ACK = 5'h04,
    LS_SEND = 5'h08,
    LS_RACK = 5'h10
  } sie_lst_type;
  // byte position in a frame
  localparam logic [1:0] PH_ADDR = 2'h0;
  localparam logic [1:0] PH_CMD = 2'h1;
  localparam logic [1:0] PH_WDAT = 2'h2;

  // link domain state
  typedef struct packed {
    logic scl_q;
    logic sda_q;
    sie_lst_type st;
    logic [1:0] ph;
    logic [3:0] bitcnt;
    logic [7:0] sh;
    logic rd;
    logic ara;
    logic ack;
    logic sda_oe;
    logic busy;
    logic [sie_pkg::IDLE_W-1:0] idle;
    logic [7:0] cmd;
    sie_pkg::sie_wr_type wr;
    logic fetch_t;
    logic wr_t;
    logic rdd_t;
    logic ara_t;
  } sie_lnk_type;

  // system domain state
  typedef struct packed {
    sie_pkg::sie_regs_type regs;
    logic [7:0] rdata;
    logic alert_n;
    logic [3:0] tg_q;
    logic ack_t;
  } sie_sys_type;

  localparam sie_lnk_type LNK_RST = '{st: LS_IDLE, default: '0};
  localparam sie_sys_type SYS_RST = '{regs: sie_pkg::RST_REGS, alert_n: 1'b1,
                                      default: '0};

  sie_lnk_type l_ff;
  sie_lnk_type nxt_l;
  sie_sys_type s_ff;
  sie_sys_type nxt_s;
  logic [1:0] bus_s; // synced scl, sda
  logic [4:0] lin_s; // synced alert, fetch ack, straps
  logic [3:0] tg_s; // synced toggles in system domain
  logic [7:0] evt; // line change pulses
  logic scl_s;
  logic sda_s;
  logic alert_s;
  logic ack_s;
  logic [2:0] addr_s;
  logic rise;
  logic fall;
  logic start;
  logic stop;

  // bus pins into the link domain
  sie_sync #(.W(2)) u_bus_sync (
    .i_clk(i_lnk_clk),
    .i_nrst(i_nrst),
    .i_d({i_scl, i_sda}),
    .o_q(bus_s)
  );

  // alert level, fetch answer and straps into the link domain
  sie_sync #(.W(5)) u_lnk_sync (
    .i_clk(i_lnk_clk),
    .i_nrst(i_nrst),
    .i_d({~s_ff.alert_n, s_ff.ack_t, i_addr_sel}),
    .o_q(lin_s)
  );

  // link toggles into the system domain
  sie_sync #(.W(4)) u_sys_sync (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_d({l_ff.ara_t, l_ff.rdd_t, l_ff.wr_t, l_ff.fetch_t}),
    .o_q(tg_s)
  );

  // line drivers and change detection
  sie_port u_port (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_regs(s_ff.regs),
    .i_line(i_line),
    .o_line(o_line),
    .o_line_oe(o_line_oe),
    .o_evt(evt)
  );

  assign {scl_s, sda_s} = bus_s;
  assign {alert_s, ack_s, addr_s} = lin_s;

  // edges seen on synchronised lines only
  assign rise = ~l_ff.scl_q & scl_s;
  assign fall = l_ff.scl_q & ~scl_s;
  assign start = l_ff.scl_q & scl_s & l_ff.sda_q & ~sda_s;
  assign stop = l_ff.scl_q & scl_s & ~l_ff.sda_q & sda_s;

  // link engine next state
  always_comb
  begin
    logic [7:0] tx;
    // all ones while a fetch is still crossing
    tx = 8'hFF;
    nxt_l = l_ff;
    nxt_l.scl_q = scl_s;
    nxt_l.sda_q = sda_s;
    // answer byte: own address for ara, else fetched register
    if (l_ff.ara)
      tx = {sie_pkg::ADDR_BASE, addr_s, 1'b0};
    else if (ack_s == l_ff.fetch_t)
      tx = s_ff.rdata;
    // idle watch while both lines high
    if (scl_s && sda_s)
    begin
      if (l_ff.idle != sie_pkg::IDLE_W'(sie_pkg::IDLE_CYC))
        nxt_l.idle = l_ff.idle + 12'h001;
      else
        nxt_l.busy = 1'b0;
    end
    else
      nxt_l.idle = '0;
    unique case (l_ff.st)
      LS_IDLE:
        nxt_l.sda_oe = 1'b0;
      LS_RECV:
      begin
        if (rise)
        begin
          // shift in, first bit is msb
          nxt_l.sh = {l_ff.sh[6:0], sda_s};
          nxt_l.bitcnt = l_ff.bitcnt + 4'h1;
        end
        else if (fall && l_ff.bitcnt == 4'h8)
        begin
          nxt_l.bitcnt = 4'h0;
          nxt_l.st = LS_ACK;
          nxt_l.sda_oe = 1'b1;
          unique case (l_ff.ph)
            PH_ADDR:
            begin
              if (l_ff.sh[7:1] == {sie_pkg::ADDR_BASE, addr_s})
                nxt_l.rd = l_ff.sh[0];
              else if (l_ff.sh == {sie_pkg::ARA_ADDR, 1'b1} && alert_s)
              begin
                // answer the alert response address
                nxt_l.rd = 1'b1;
                nxt_l.ara = 1'b1;
              end
              else
              begin
                // not ours: leave the line high
                nxt_l.st = LS_IDLE;
                nxt_l.sda_oe = 1'b0;
              end
            end
            PH_CMD:
            begin
              // command selects register, fetch it now
              nxt_l.cmd = l_ff.sh;
              nxt_l.fetch_t = ~l_ff.fetch_t;
            end
            default:
            begin
              // data byte goes to the register file
              nxt_l.wr = '{cmd: l_ff.cmd, dat: l_ff.sh};
              nxt_l.wr_t = ~l_ff.wr_t;
            end
          endcase
        end
      end
      LS_ACK:
      begin
        if (fall)
        begin
          nxt_l.sda_oe = 1'b0;
          if (l_ff.rd)
          begin
            // present first bit of the answer
            nxt_l.st = LS_SEND;
            nxt_l.sh = tx;
            nxt_l.sda_oe = ~tx[7];
          end
          else
          begin
            nxt_l.st = LS_RECV;
            if (l_ff.ph != PH_WDAT)
              nxt_l.ph = l_ff.ph + 2'h1;
          end
        end
      end
      LS_SEND:
      begin
        if (fall)
        begin
          if (l_ff.bitcnt == 4'h7)
          begin
            // release for the host acknowledge
            nxt_l.st = LS_RACK;
            nxt_l.sda_oe = 1'b0;
            nxt_l.bitcnt = 4'h0;
          end
          else
          begin
            nxt_l.sh = {l_ff.sh[6:0], 1'b0};
            nxt_l.sda_oe = ~l_ff.sh[6];
            nxt_l.bitcnt = l_ff.bitcnt + 4'h1;
          end
        end
      end
      LS_RACK:
      begin
        if (rise)
        begin
          // byte delivered: report it across
          nxt_l.ack = ~sda_s;
          if (l_ff.ara)
            nxt_l.ara_t = ~l_ff.ara_t;
          else
            nxt_l.rdd_t = ~l_ff.rdd_t;
        end
        else if (fall)
        begin
          if (l_ff.ack)
          begin
            nxt_l.st = LS_SEND;
            nxt_l.sh = tx;
            nxt_l.sda_oe = ~tx[7];
          end
          else
            nxt_l.st = LS_IDLE;
        end
      end
      default:
        nxt_l.st = LS_IDLE;
    endcase
    // start and stop override any state
    if (start)
    begin
      nxt_l.st = LS_RECV;
      nxt_l.ph = PH_ADDR;
      nxt_l.bitcnt = 4'h0;
      nxt_l.sda_oe = 1'b0;
      nxt_l.busy = 1'b1;
      nxt_l.rd = 1'b0;
      nxt_l.ara = 1'b0;
    end
    else if (stop)
    begin
      nxt_l.st = LS_IDLE;
      nxt_l.sda_oe = 1'b0;
      nxt_l.busy = 1'b0;
    end
  end

  // link register
  always_ff @(posedge i_lnk_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      l_ff <= LNK_RST;
    else
      l_ff <= nxt_l;
  end

  // register file next state
  always_comb
  begin
    logic [3:0] tg_e;
    logic [7:0] clr;
    logic rd_stat;
    tg_e = tg_s ^ s_ff.tg_q;
    clr = 8'h00;
    rd_stat = 1'b0;
    nxt_s = s_ff;
    nxt_s.tg_q = tg_s;
    // fetch: link command held stable
    if (tg_e[0])
    begin
      unique case (l_ff.cmd)
        sie_pkg::CMD_CFG: nxt_s.rdata = s_ff.regs.cfg;
        sie_pkg::CMD_DIR: nxt_s.rdata = s_ff.regs.dir;
        sie_pkg::CMD_DRV: nxt_s.rdata = s_ff.regs.drv;
        sie_pkg::CMD_STAT: nxt_s.rdata = s_ff.regs.stat;
        sie_pkg::CMD_MASK: nxt_s.rdata = s_ff.regs.mask;
        sie_pkg::CMD_DATA: nxt_s.rdata = s_ff.regs.data;
        sie_pkg::CMD_FAN: nxt_s.rdata = s_ff.regs.fan;
        default: nxt_s.rdata = 8'h00;
      endcase
      nxt_s.ack_t = ~s_ff.ack_t;
    end
    // write: status is read only, other codes ignored
    if (tg_e[1])
    begin
      unique case (l_ff.wr.cmd)
        sie_pkg::CMD_CFG: nxt_s.regs.cfg = l_ff.wr.dat;
        sie_pkg::CMD_DIR: nxt_s.regs.dir = l_ff.wr.dat;
        sie_pkg::CMD_DRV: nxt_s.regs.drv = l_ff.wr.dat;
        sie_pkg::CMD_MASK: nxt_s.regs.mask = l_ff.wr.dat;
        sie_pkg::CMD_DATA: nxt_s.regs.data = l_ff.wr.dat;
        sie_pkg::CMD_FAN: nxt_s.regs.fan = l_ff.wr.dat;
        default: nxt_s.regs = s_ff.regs;
      endcase
    end
    // status read clears only what it reported
    rd_stat = tg_e[2] && l_ff.cmd == sie_pkg::CMD_STAT;
    clr = rd_stat ? s_ff.rdata : 8'h00;
    nxt_s.regs.stat = (s_ff.regs.stat & ~clr) | evt;
    // alert: release first, a new event wins
    if (rd_stat || tg_e[3])
      nxt_s.alert_n = 1'b1;
    if (s_ff.regs.cfg[sie_pkg::CFG_IE_BIT] && |(evt & s_ff.regs.mask))
      nxt_s.alert_n = 1'b0;
  end

  // register file, power-on values
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      s_ff <= SYS_RST;
    else
      s_ff <= nxt_s;
  end

  assign o_sda = 1'b0;
  assign o_sda_oe = l_ff.sda_oe;
  assign o_alert_n = s_ff.alert_n;
  assign o_bus_busy = l_ff.busy;

  // end of a received byte
  sequence s_byte_end;
    l_ff.st == LS_RECV && fall && l_ff.bitcnt == 4'h8;
  endsequence

  AST_START_RECV : assert property (@(posedge i_lnk_clk) disable iff (!i_nrst)
    start |=> (l_ff.st == LS_RECV && l_ff.ph == PH_ADDR && l_ff.busy))
    else $error("start not taken");
  AST_STOP_IDLE : assert property (@(posedge i_lnk_clk) disable iff (!i_nrst)
    stop |=> (l_ff.st == LS_IDLE && !l_ff.busy && !l_ff.sda_oe))
    else $error("stop not taken");
  AST_BUS_FREE : assert property (@(posedge i_lnk_clk) disable iff (!i_nrst)
    (scl_s && sda_s && l_ff.idle == sie_pkg::IDLE_W'(sie_pkg::IDLE_CYC)) |=> !l_ff.busy)
    else $error("bus not freed after idle time");
  AST_ACK_AFTER8 : assert property (@(posedge i_lnk_clk) disable iff (!i_nrst)
    (l_ff.st == LS_ACK && $past(l_ff.st) == LS_RECV) |-> $past(l_ff.bitcnt) == 4'h8)
    else $error("ack slot not after eight bits");
  AST_ACK_LOW : assert property (@(posedge i_lnk_clk) disable iff (!i_nrst)
    (s_byte_end ##1 (l_ff.st == LS_ACK)) |-> l_ff.sda_oe)
    else $error("acknowledge not driven");
  AST_MSB_FIRST : assert property (@(posedge i_lnk_clk) disable iff (!i_nrst)
    (l_ff.st == LS_SEND && fall && l_ff.bitcnt != 4'h7) |=> l_ff.sda_oe == ~$past(l_ff.sh[6]))
    else $error("bit order wrong");
  AST_RACK_FREE : assert property (@(posedge i_lnk_clk) disable iff (!i_nrst)
    l_ff.st == LS_RACK |-> !l_ff.sda_oe)
    else $error("data not released in host ack slot");
  AST_STAT_SET : assert property (@(posedge i_clk) disable iff (!i_nrst)
    (|evt) |=> (s_ff.regs.stat & $past(evt)) == $past(evt))
    else $error("input change lost");
  AST_ALERT_GATE : assert property (@(posedge i_clk) disable iff (!i_nrst)
    $fell(s_ff.alert_n) |-> $past(s_ff.regs.cfg[sie_pkg::CFG_IE_BIT] && |(evt & s_ff.regs.mask)))
    else $error("alert without enable and mask");
endmodule : sie_core
`default_nettype wire

/* File: verification/sie_host.sv */
// bus host model: start, stop, bit and byte transfers on clock and data
`timescale 1ns/1ps
`default_nettype none
module sie_host #(
  parameter int Q = 7
) (
  // system clock paces the host
  input wire logic i_clk,
  // data wire level as seen on the bus
  input wire logic i_sda,
  // host drive, high = released to pull-up
  output logic o_scl,
  output logic o_sda
);
  // bus idle, both lines released
  initial
  begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end
  // one quarter of a bit time
  task automatic qw();
    repeat (Q) @(posedge i_clk);
  endtask : qw
  // start or repeated start: data falls while clock high
  task automatic start();
    o_sda <= 1'b1;
    qw();
    o_scl <= 1'b1;
    qw();
    o_sda <= 1'b0;
    qw();
    o_scl <= 1'b0;
    qw();
  endtask : start
  // stop: data rises while clock high
  task automatic stop();
    o_sda <= 1'b0;
    qw();
    o_scl <= 1'b1;
    qw();
    o_sda <= 1'b1;
    qw();
  endtask : stop
  // clock released without a stop, bus left parked high
  task automatic park();
    o_scl <= 1'b1;
  endtask : park
  // one bit: data set in low phase, held and sampled in high phase
  task automatic bit_io(input logic b, output logic s);
    o_sda <= b;
    qw();
    o_scl <= 1'b1;
    qw();
    s = i_sda;
    qw();
    o_scl <= 1'b0;
    qw();
  endtask : bit_io
  // eight bits msb first, then the ack slot clocked by the host
  task automatic byte_io(input logic [7:0] tx, input logic last, output logic [7:0] rx,
                         output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(tx[i], s);
      rx[i] = s;
    end
    bit_io(last, s);
    ack = ~s;
  endtask : byte_io
endmodule : sie_host
`default_nettype wire

/* File: verification/sie_core_bench.sv */
// self-checking testbench of the serial i/o expander core
`timescale 1ns/1ps
`default_nettype none
module sie_core_bench;
  localparam logic [6:0] DEV = {sie_pkg::ADDR_BASE, 3'h5};
  // clocks, reset and pins
  logic clk = 1'b0;
  logic lnk_clk = 1'b0;
  logic nrst = 1'b0;
  logic [2:0] addr_sel = 3'h5;
  logic [7:0] line_in = 8'h00;
  logic scl_h, sda_h, sda_o, sda_oe, sda_w, alert_n, busy, s, a;
  logic [7:0] line_o, line_oe, rx;
  // counters
  int num_errors = 0;
  int n_tests = 0;
  int cyc = 0;
  // open-drain data wire with pull-up
  assign sda_w = sda_h & ~(sda_oe & ~sda_o);
  // system and link clocks, rising edges never coincide
  always #20 clk = ~clk;
  always #7.5 lnk_clk = ~lnk_clk;
  sie_core sie_core_inst (.i_clk(clk), .i_lnk_clk(lnk_clk), .i_nrst(nrst), .i_scl(scl_h),
    .i_sda(sda_w), .o_sda(sda_o), .o_sda_oe(sda_oe), .i_addr_sel(addr_sel), .i_line(line_in),
    .o_line(line_o), .o_line_oe(line_oe), .o_alert_n(alert_n), .o_bus_busy(busy));
  sie_host sie_host_inst (.i_clk(clk), .i_sda(sda_w), .o_scl(scl_h), .o_sda(sda_h));
  // compare and count
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // verdict and end of run
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up
  // write: address, command, data, each acknowledged
  task automatic wr(input logic [7:0] cmd, input logic [7:0] dat);
    logic [7:0] r;
    logic [2:0] k;
    sie_host_inst.start();
    sie_host_inst.byte_io({DEV, 1'b0}, 1'b1, r, k[2]);
    sie_host_inst.byte_io(cmd, 1'b1, r, k[1]);
    sie_host_inst.byte_io(dat, 1'b1, r, k[0]);
    sie_host_inst.stop();
    check({5'h00, k}, 8'h07);
  endtask : wr
  // read: address, command, repeated start, address, data with host nack
  task automatic rd(input logic [7:0] cmd, input logic [7:0] exp);
    logic [7:0] r;
    logic [3:0] k;
    sie_host_inst.start();
    sie_host_inst.byte_io({DEV, 1'b0}, 1'b1, r, k[3]);
    sie_host_inst.byte_io(cmd, 1'b1, r, k[2]);
    sie_host_inst.start();
    sie_host_inst.byte_io({DEV, 1'b1}, 1'b1, r, k[1]);
    sie_host_inst.byte_io(8'hFF, 1'b1, r, k[0]);
    sie_host_inst.stop();
    check({4'h0, k}, 8'h0E);
    check(r, exp);
  endtask : rd
  // hang guard
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 90000)
    begin
      num_errors++;
      wrap_up();
    end
  end
  // main sequence
  initial
  begin
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    repeat (6) @(posedge clk);
    check({busy, alert_n, 6'h00}, 8'h40);
    check(line_oe, 8'h00);
    for (int i = 0; i < 8; i++)
      rd(i[7:0], (i == 5) ? 8'hFF : 8'h00);
    $display("test defaults done");
    wr(sie_pkg::CMD_DATA, 8'hA5);
    wr(sie_pkg::CMD_DRV, 8'h0F);
    check(line_oe, 8'h00);
    wr(sie_pkg::CMD_DIR, 8'hFF);
    check(line_oe, 8'h5F);
    check(line_o, 8'h05);
    rd(sie_pkg::CMD_DATA, 8'hA5);
    wr(sie_pkg::CMD_DATA, (8'hA5 | 8'h10) & ~8'h04);
    check(line_oe, 8'h4F);
    check(line_o, 8'h01);
    line_in <= 8'hFF;
    repeat (10) @(posedge clk);
    rd(sie_pkg::CMD_STAT, 8'h00);
    $display("test outputs done");
    wr(sie_pkg::CMD_DIR, 8'h00);
    wr(sie_pkg::CMD_MASK, 8'h01);
    rd(sie_pkg::CMD_STAT, 8'h00);
    wr(sie_pkg::CMD_CFG, 8'h02);
    line_in <= 8'hFE;
    repeat (10) @(posedge clk);
    check({7'h00, alert_n}, 8'h00);
    rd(sie_pkg::CMD_STAT, 8'h01);
    check({7'h00, alert_n}, 8'h01);
    rd(sie_pkg::CMD_STAT, 8'h00);
    line_in <= 8'hFC;
    repeat (10) @(posedge clk);
    check({7'h00, alert_n}, 8'h01);
    rd(sie_pkg::CMD_STAT, 8'h02);
    wr(sie_pkg::CMD_CFG, 8'h00);
    line_in <= 8'hFD;
    repeat (10) @(posedge clk);
    check({7'h00, alert_n}, 8'h01);
    rd(sie_pkg::CMD_STAT, 8'h01);
    $display("test status and alert done");
    wr(sie_pkg::CMD_CFG, 8'h02);
    line_in <= 8'hFC;
    repeat (10) @(posedge clk);
    sie_host_inst.start();
    sie_host_inst.byte_io({sie_pkg::ARA_ADDR, 1'b1}, 1'b1, rx, a);
    sie_host_inst.byte_io(8'hFF, 1'b1, rx, s);
    sie_host_inst.stop();
    check({a, rx[7:1]}, {1'b1, DEV});
    check({7'h00, alert_n}, 8'h01);
    rd(sie_pkg::CMD_STAT, 8'h01);
    sie_host_inst.start();
    sie_host_inst.byte_io({DEV ^ 7'h01, 1'b0}, 1'b1, rx, a);
    sie_host_inst.stop();
    check({7'h00, a}, 8'h00);
    $display("test alert response done");
    wr(sie_pkg::CMD_CFG, 8'h00);
    wr(sie_pkg::CMD_FAN, 8'h05);
    check(line_oe, 8'h00);
    wr(sie_pkg::CMD_CFG, 8'h01);
    check(line_oe, 8'hA0);
    line_in <= 8'h0C;
    repeat (10) @(posedge clk);
    rd(sie_pkg::CMD_STAT, 8'h00);
    wr(sie_pkg::CMD_FAN, 8'h00);
    check(line_oe, 8'h10);
    $display("test fan mode done");
    sie_host_inst.start();
    check({7'h00, busy}, 8'h01);
    sie_host_inst.bit_io(1'b1, s);
    sie_host_inst.park();
    repeat (1150) @(posedge clk);
    check({7'h00, busy}, 8'h01);
    repeat (250) @(posedge clk);
    check({7'h00, busy}, 8'h00);
    wr(sie_pkg::CMD_MASK, 8'h03);
    check({7'h00, busy}, 8'h00);
    rd(sie_pkg::CMD_MASK, 8'h03);
    $display("test bus state done");
    wrap_up();
  end
endmodule : sie_core_bench
`default_nettype wire
